// [hdl/tlic_top.sv]
// two-level interrupt controller with wishbone register slave
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`include "tlic_params.svh"
module tlic_top #(
    parameter int ADR_W = 8
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [ADR_W-1:0]         wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // interrupt sources
    input  wire logic [`TLIC_NUM_SRC-1:0] srcEvent,
    input  wire logic                     supplyGoodIndication,
    // cpu core handshake
    input  wire logic                     cpuInstrDone,
    input  wire logic                     cpuRetiDone,
    input  wire logic                     cpuCallAck,
    output logic                          irqReq,
    output logic      [15:0]              irqVector,
    output logic                          irqHigh,
    // summary interrupt
    output logic                          intOut
);
    localparam int N = `TLIC_NUM_SRC;

    // elaboration refuses an address bus too narrow for the 8-bit map
    if (ADR_W < 8) begin : g_adrCheck
        $error("tlic_top: ADR_W must be at least 8");
    end

    // lowest set bit wins, giving the fixed order 0 first
    function automatic logic [4:0] firstSet(input logic [N-1:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i])
                idx = 5'(i);
        end
        return idx;
    endfunction

    // byte enables spread to a bit mask
    function automatic logic [31:0] laneMask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    // service address of a source
    function automatic logic [15:0] vecOf(input logic [4:0] idx);
        return `TLIC_VEC_BASE + (16'(idx) << `TLIC_VEC_SHIFT);
    endfunction

    // register state
    logic [7:0]          ie_q;
    logic [7:0]          ie_d;
    logic [6:0]          ip_q;
    logic [6:0]          ip_d;
    logic [7:0]          ext_irq_enable_reg1_q;
    logic [7:0]          ext_irq_enable_reg1_d;
    logic [3:0]          ext_irq_enable_reg2_q;
    logic [3:0]          ext_irq_enable_reg2_d;
    logic [7:0]          ext_irq_priority_reg1_q;
    logic [7:0]          ext_irq_priority_reg1_d;
    logic [3:0]          ext_irq_priority_reg2_q;
    logic [3:0]          ext_irq_priority_reg2_d;
    logic [N-1:0]        pend_q;
    logic [N-1:0]        pend_d;
    logic [N-1:0]        sampled_q;
    logic [`TLIC_EV_W-1:0] stat_q;
    logic [`TLIC_EV_W-1:0] stat_d;
    logic [`TLIC_EV_W-1:0] mask_q;
    logic [`TLIC_EV_W-1:0] mask_d;
    logic                svcLow_q;
    logic                svcHigh_q;
    logic [4:0]          irqIdx_q;
    tlic_pkg::tlic_gate_t gate_q;
    tlic_pkg::tlic_gate_t gate_d;

    // bus decode
    wire         busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire         wrStb   = busReq & wb_we_i;
    wire         rdStb   = busReq & ~wb_we_i;
    wire  [7:0]  ofs     = wb_adr_i[7:0];
    wire  [31:0] wMask   = laneMask(wb_sel_i);
    wire  [31:0] wBits   = wb_dat_i & wMask;
    wire         wLane0  = wrStb & wb_sel_i[0];
    wire         hitIe   = (ofs == `TLIC_OFS_IE);
    wire         hitIp   = (ofs == `TLIC_OFS_IP);
    wire         hitEie1 = (ofs == `TLIC_OFS_EXT_IRQ_ENABLE_REG1);
    wire         hitEie2 = (ofs == `TLIC_OFS_EXT_IRQ_ENABLE_REG2);
    wire         hitEip1 = (ofs == `TLIC_OFS_EXT_IRQ_PRIORITY_REG1);
    wire         hitEip2 = (ofs == `TLIC_OFS_EXT_IRQ_PRIORITY_REG2);
    wire         hitPset = (ofs == `TLIC_OFS_PSET);
    wire         hitPclr = (ofs == `TLIC_OFS_PCLR);
    wire         hitStat = (ofs == `TLIC_OFS_STAT);
    wire         hitMask = (ofs == `TLIC_OFS_MASK);

    // per-source enable and priority views
    wire [N-1:0] roMask  = N'(1) << `TLIC_RO_SRC;
    wire [N-1:0] enVec   = {ext_irq_enable_reg2_q, ext_irq_enable_reg1_q, ie_q[`TLIC_IE_LO_W-1:0]};
    wire [N-1:0] prVec   = {ext_irq_priority_reg2_q, ext_irq_priority_reg1_q, ip_q};
    wire         genEn   = ie_q[`TLIC_GEN_BIT];
    // supply warning is a live level, never latched here
    wire [N-1:0] srcPend = (pend_q & ~roMask)
                         | (N'(supplyGoodIndication) << `TLIC_RO_SRC); // RULE16
    wire [N-1:0] armed   = srcPend & enVec & {N{genEn}}; // RULE1 RULE2 RULE17

    // software set and clear of pending flags
    wire [N-1:0] swSet   = (wrStb & hitPset) ? wBits[N-1:0] & ~roMask
                                             : '0; // RULE5 RULE16
    wire [N-1:0] swClr   = (wrStb & hitPclr) ? wBits[N-1:0] : '0;
    wire [N-1:0] hwClr   = cpuCallAck ? (N'(1) << irqIdx_q) & `TLIC_HWCLR_MASK
                                      : '0; // RULE15

    // arbitration: high level may preempt low, nothing preempts high
    wire [N-1:0] hiCand  = sampled_q & prVec & {N{~svcHigh_q}}; // RULE6 RULE7
    wire [N-1:0] loCand  = sampled_q & ~prVec
                         & {N{~svcHigh_q & ~svcLow_q}}; // RULE7 RULE14
    wire         pickHi  = |hiCand; // RULE9
    wire         pickAny = pickHi | (|loCand);
    wire [4:0]   pickIdx = pickHi ? firstSet(hiCand) : firstSet(loCand); // RULE9
    wire         gateOpen = (gate_q == tlic_pkg::GATE_OPEN);
    // request drops on the call handshake so the ack never double-counts
    wire         irqReqD = pickAny & gateOpen & ~cpuRetiDone
                         & ~cpuCallAck; // RULE12 RULE14 RULE18 RULE19

    // event sources for the summary status
    wire [`TLIC_EV_W-1:0] evNow;
    assign evNow[`TLIC_EV_CALL] = cpuCallAck;
    assign evNow[`TLIC_EV_RETURN_FROM_IRQ_INSTR] = cpuRetiDone;
    assign evNow[`TLIC_EV_HELD] = ~genEn & (|(srcPend & enVec)); // RULE3
    wire [`TLIC_EV_W-1:0] statClr = (rdStb & hitStat) ? stat_q : '0;

    // register next values
    assign ie_d   = (wLane0 & hitIe)   ? wb_dat_i[7:0] : ie_q;
    assign ip_d   = (wLane0 & hitIp)   ? wb_dat_i[6:0] : ip_q;
    assign ext_irq_enable_reg1_d = (wLane0 & hitEie1) ? wb_dat_i[7:0] : ext_irq_enable_reg1_q;
    assign ext_irq_enable_reg2_d = (wLane0 & hitEie2) ? wb_dat_i[3:0] : ext_irq_enable_reg2_q;
    assign ext_irq_priority_reg1_d = (wLane0 & hitEip1) ? wb_dat_i[7:0] : ext_irq_priority_reg1_q;
    assign ext_irq_priority_reg2_d = (wLane0 & hitEip2) ? wb_dat_i[3:0] : ext_irq_priority_reg2_q;
    assign mask_d = (wLane0 & hitMask) ? wb_dat_i[`TLIC_EV_W-1:0] : mask_q;
    // a set in the same cycle as a clear wins so no event is lost
    assign pend_d = ((pend_q & ~swClr & ~hwClr) | srcEvent | swSet)
                  & ~roMask; // RULE3 RULE17 RULE19
    assign stat_d = (stat_q & ~statClr) | evNow;

    // read data selection, unmapped offsets read zero
    wire [31:0] rdData =
        hitIe   ? {24'h000000, ie_q} :
        hitIp   ? {24'h000000, `TLIC_IP_RSVD | {1'b0, ip_q}} :
        hitEie1 ? {24'h000000, ext_irq_enable_reg1_q} :
        hitEie2 ? {28'h0000000, ext_irq_enable_reg2_q} :
        hitEip1 ? {24'h000000, ext_irq_priority_reg1_q} :
        hitEip2 ? {28'h0000000, ext_irq_priority_reg2_q} :
        hitPset ? {13'h0000, srcPend} :
        hitStat ? {29'h00000000, stat_q} :
        hitMask ? {29'h00000000, mask_q} : 32'h0000_0000;

    // return gate: after a return, one instruction must complete first
    always_comb begin
        gate_d = gate_q;
        unique case (gate_q)
            tlic_pkg::GATE_OPEN: begin
                if (cpuRetiDone)
                    gate_d = tlic_pkg::GATE_HOLD; // RULE12 RULE18
            end
            tlic_pkg::GATE_HOLD: begin
                if (cpuInstrDone & ~cpuRetiDone)
                    gate_d = tlic_pkg::GATE_OPEN; // RULE12 RULE13 RULE14
            end
        endcase
    end

    // configuration registers; priorities reset to low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ie_q   <= 8'h00;
            ip_q   <= 7'h00; // RULE8
            ext_irq_enable_reg1_q <= 8'h00;
            ext_irq_enable_reg2_q <= 4'h0;
            ext_irq_priority_reg1_q <= 8'h00; // RULE8
            ext_irq_priority_reg2_q <= 4'h0; // RULE8
            mask_q <= 3'h0;
        end else begin
            ie_q   <= ie_d;
            ip_q   <= ip_d;
            ext_irq_enable_reg1_q <= ext_irq_enable_reg1_d;
            ext_irq_enable_reg2_q <= ext_irq_enable_reg2_d;
            ext_irq_priority_reg1_q <= ext_irq_priority_reg1_d;
            ext_irq_priority_reg2_q <= ext_irq_priority_reg2_d;
            mask_q <= mask_d;
        end
    end

    // pending flags and per-cycle sampling of the armed requests
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_q    <= '0;
            sampled_q <= '0;
            stat_q    <= 3'h0;
            intOut    <= 1'b0;
        end else begin
            pend_q    <= pend_d;
            sampled_q <= armed; // RULE10 RULE11
            stat_q    <= stat_d;
            intOut    <= |(stat_q & mask_q);
        end
    end

    // in-service levels: high nests over low, return pops the top one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            svcLow_q  <= 1'b0;
            svcHigh_q <= 1'b0;
        end else if (cpuCallAck) begin
            if (irqHigh)
                svcHigh_q <= 1'b1; // RULE6
            else
                svcLow_q <= 1'b1;
        end else if (cpuRetiDone) begin
            if (svcHigh_q)
                svcHigh_q <= 1'b0; // RULE6
            else
                svcLow_q <= 1'b0;
        end
    end

    // cpu request and vector, held from flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gate_q    <= tlic_pkg::GATE_OPEN;
            irqReq    <= 1'b0;
            irqVector <= `TLIC_RESET_VEC; // RULE4
            irqHigh   <= 1'b0;
            irqIdx_q  <= 5'h00;
        end else begin
            gate_q <= gate_d;
            irqReq <= irqReqD;
            if (irqReqD) begin
                irqVector <= vecOf(pickIdx); // RULE4
                irqHigh   <= pickHi;
                irqIdx_q  <= pickIdx;
            end
        end
    end

    // wishbone answer one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= rdStb ? rdData : 32'h0000_0000;
        end
    end

    // ---- assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_quiet;
        !cpuRetiDone && !cpuCallAck;
    endsequence
    sequence s_armedIdle;
        (|armed) && gateOpen && !svcLow_q && !svcHigh_q && !cpuRetiDone
            && !cpuCallAck;
    endsequence

    property p_genGate;
        !genEn [*2] |=> !irqReq;
    endproperty
    a_genGate: assert property (p_genGate) // RULE1
        else $error("request raised while globally disabled");

    property p_heldPending;
        (!genEn && !cpuCallAck && !(wrStb && hitPclr))
            |=> ((pend_q & $past(pend_q)) == $past(pend_q));
    endproperty
    a_heldPending: assert property (p_heldPending) // RULE3
        else $error("pending flag lost while disabled");

    property p_vector;
        irqReq |-> (irqVector == vecOf(irqIdx_q))
            && (irqVector <= `TLIC_VEC_LAST);
    endproperty
    a_vector: assert property (p_vector) // RULE4
        else $error("vector does not match source");

    property p_swSet;
        (|swSet) |=> ((pend_q & $past(swSet)) == $past(swSet));
    endproperty
    a_swSet: assert property (p_swSet) // RULE5
        else $error("software set did not take");

    property p_noPreemptHigh;
        svcHigh_q |-> !irqReq;
    endproperty
    a_noPreemptHigh: assert property (p_noPreemptHigh) // RULE7
        else $error("high routine preempted");

    property p_lowOnlyByHigh;
        (svcLow_q && irqReq) |-> irqHigh;
    endproperty
    a_lowOnlyByHigh: assert property (p_lowOnlyByHigh) // RULE6
        else $error("low routine preempted by low request");

    property p_resetLow;
        $past(rst) |-> (prVec == '0);
    endproperty
    a_resetLow: assert property (p_resetLow) // RULE8
        else $error("priority not low after reset");

    property p_levelFirst;
        $rose(irqReq) && !irqHigh |-> ($past(hiCand) == '0);
    endproperty
    a_levelFirst: assert property (p_levelFirst) // RULE9
        else $error("low served over high");

    property p_detect;
        s_armedIdle ##1 s_quiet |=> irqReq;
    endproperty
    a_detect: assert property (p_detect) // RULE11
        else $error("request not raised two cycles after arming");

    property p_retiHold;
        cpuRetiDone ##1 !cpuInstrDone |-> !irqReq;
    endproperty
    a_retiHold: assert property (p_retiHold) // RULE12
        else $error("call issued before next instruction");

    property p_hwClear;
        (cpuCallAck && irqIdx_q < 5'd4 && !srcEvent[irqIdx_q]
            && !swSet[irqIdx_q]) |=> !pend_q[$past(irqIdx_q)];
    endproperty
    a_hwClear: assert property (p_hwClear) // RULE15
        else $error("pin or timer flag not cleared on vectoring");

    property p_readOnly;
        !pend_q[`TLIC_RO_SRC];
    endproperty
    a_readOnly: assert property (p_readOnly) // RULE16
        else $error("read-only flag latched");

    property p_eventSets;
        (|(srcEvent & ~roMask))
            |=> ((pend_q & $past(srcEvent & ~roMask))
                 == $past(srcEvent & ~roMask));
    endproperty
    a_eventSets: assert property (p_eventSets) // RULE17
        else $error("event did not set pending flag");

    // a long instruction after a return keeps the gate shut throughout
    property p_holdQuiet;
        (gate_q == tlic_pkg::GATE_HOLD) |=> !irqReq;
    endproperty
    a_holdQuiet: assert property (p_holdQuiet) // RULE13
        else $error("request raised while return gate held");

    property p_offNoArm;
        !genEn |-> (armed == '0);
    endproperty
    a_offNoArm: assert property (p_offNoArm) // RULE2
        else $error("source armed while globally disabled");

endmodule // tlic_top

// [inc/tlic_params.svh]
// constants of the two-level interrupt controller
// Contract
// RULE1: individual source enables count only while the global enable bit 7 is set
// RULE2: global enable low means no CPU request from any source
// RULE3: requests arriving while globally disabled stay pending until re-enabled
// RULE4: vectors are 0x0000 for reset, 0x0003 first, then every 8 bytes to 0x0093
// RULE5: software setting a pending flag requests exactly like a hardware event
// RULE6: each source is low or high; high may preempt a running low routine
// RULE7: a running high routine is never preempted
// RULE8: all priority bits select low after reset
// RULE9: simultaneous requests: high level first, then lowest source number
// RULE10: pending requests are sampled and priority decoded every clock
// RULE11: fastest response is 7 clocks: detect, one instruction, 5-cycle call
// RULE12: after a return, one more instruction completes before the next call
// RULE13: worst response is 19 clocks: detect, return, divide, call
// RULE14: a request not above the routine in service waits for return plus one
// RULE15: hardware clears pin and timer flags of sources 0 to 3 on vectoring
// RULE16: supply warning flag is read-only; only its enable stops vectoring
// RULE17: flags set on events regardless of enables; request needs all three set
// RULE18: a flag still set after return requests again after the next instruction
// RULE19: a shared-vector request stays asserted until all its flags are clear
`ifndef TLIC_PARAMS_SVH
`define TLIC_PARAMS_SVH
`define TLIC_NUM_SRC     19
`define TLIC_GEN_BIT     7
`define TLIC_RO_SRC      15
`define TLIC_HWCLR_MASK  19'h0000F
`define TLIC_IP_RSVD     8'h80
`define TLIC_RESET_VEC   16'h0000
`define TLIC_VEC_BASE    16'h0003
`define TLIC_VEC_LAST    16'h0093
`define TLIC_VEC_SHIFT   3
`define TLIC_MIN_RESP    7
`define TLIC_CALL_CYC    5
`define TLIC_MAX_RESP    19
`define TLIC_OFS_IE      8'h00
`define TLIC_OFS_IP      8'h04
`define TLIC_OFS_EXT_IRQ_ENABLE_REG1    8'h08
`define TLIC_OFS_EXT_IRQ_ENABLE_REG2    8'h0C
`define TLIC_OFS_EXT_IRQ_PRIORITY_REG1    8'h10
`define TLIC_OFS_EXT_IRQ_PRIORITY_REG2    8'h14
`define TLIC_OFS_PSET    8'h18
`define TLIC_OFS_PCLR    8'h1C
`define TLIC_OFS_STAT    8'h20
`define TLIC_OFS_MASK    8'h24
`define TLIC_EV_CALL     0
`define TLIC_EV_RETURN_FROM_IRQ_INSTR     1
`define TLIC_EV_HELD     2
`define TLIC_EV_W        3
`define TLIC_IE_LO_W     7
`define TLIC_EXT2_W      4
`endif

// [inc/tlic_pkg.sv]
// types of the two-level interrupt controller
package tlic_pkg;
    // gate that holds off a new call until one instruction after a return
    typedef enum logic {GATE_OPEN, GATE_HOLD} tlic_gate_t;
endpackage

// [sim/tlic_cpu_model.sv]
// behavioural cpu core: takes calls, runs returns and single instructions
`timescale 1ns/1ns
module tlic_cpu_model (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // request from the controller
    input  wire logic irqReq,
    input  wire logic irqHigh,
    // completion strobes to the controller
    output logic      cpuInstrDone,
    output logic      cpuRetiDone,
    output logic      cpuCallAck
);
    bit svcLevel[$];  // nesting stack of routines in service

    // quiet strobes from time zero; a reset forgets any nesting
    initial begin
        cpuInstrDone = 1'b0;
        cpuRetiDone  = 1'b0;
        cpuCallAck   = 1'b0;
    end
    always @(posedge rst) svcLevel.delete();

    // take a call after a stall; acks only a request seen standing
    task automatic take_call(input int stall, output bit ok);
        int n;
        n = 0;
        repeat (stall + 1) @(posedge sys_clk);
        while (irqReq !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        ok = (irqReq === 1'b1);
        if (ok) begin
            svcLevel.push_back(irqHigh);
            cpuCallAck <= 1'b1;
            @(posedge sys_clk);
            cpuCallAck <= 1'b0;
        end
    endtask

    // return from the newest routine; the older one resumes
    task automatic return_from_irq_instr();
        @(posedge sys_clk);
        if (svcLevel.size() > 0) void'(svcLevel.pop_back());
        cpuRetiDone <= 1'b1;
        @(posedge sys_clk);
        cpuRetiDone <= 1'b0;
    endtask

    // one completed instruction, kept apart from any return
    task automatic instr();
        @(posedge sys_clk);
        cpuInstrDone <= 1'b1;
        @(posedge sys_clk);
        cpuInstrDone <= 1'b0;
    endtask
endmodule // tlic_cpu_model

// [sim/tlic_tb_top.sv]
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ns
`include "tlic_params.svh"
module tlic_tb_top;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'hF;
    logic [31:0] rdat;
    logic        ack;
    logic [18:0] srcEvent = 19'h0;
    logic        supplyGood = 1'b0;
    logic        instrDone;
    logic        retiDone;
    logic        callAck;
    logic        irqReq;
    logic [15:0] irqVector;
    logic        irqHigh;
    logic        intOut;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;
    bit          ok;
    logic [16:0] expVec[$];  // {level, vector} per expected call
    logic [63:0] expRd[$];   // {mask, value} per expected read

    tlic_top #(.ADR_W(8)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .srcEvent(srcEvent),
        .supplyGoodIndication(supplyGood), .cpuInstrDone(instrDone),
        .cpuRetiDone(retiDone), .cpuCallAck(callAck), .irqReq(irqReq),
        .irqVector(irqVector), .irqHigh(irqHigh), .intOut(intOut));
    tlic_cpu_model u_cpu (
        .sys_clk(sys_clk), .rst(rst), .irqReq(irqReq), .irqHigh(irqHigh),
        .cpuInstrDone(instrDone), .cpuRetiDone(retiDone),
        .cpuCallAck(callAck));

    initial forever #2 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // single classic cycle; request held until the edge that sees ack
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        cyc <= 1'b0;
        stb <= 1'b0;
        check(32'(n < 50), 32'h1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] v, m);
        expRd.push_back({m, v});
        bus(1'b0, a, 32'h0, 4'hF);
    endtask

    // note the vector, then let the core take it after a random stall
    task automatic call(input int s, input logic hi);
        expVec.push_back({hi, 16'h0003 + 16'(8 * s)});
        u_cpu.take_call($urandom_range(3, 0), ok);
        check(32'(ok), 32'h1);
    endtask

    // no request may show for n cycles
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            check(32'(irqReq), 32'h0);
        end
    endtask

    task automatic retire();
        u_cpu.return_from_irq_instr();
        u_cpu.instr();
    endtask

    // watcher: the oldest note meets each taken call or read answer
    always @(posedge sys_clk) begin
        logic [63:0] e;
        logic [16:0] v;
        if (callAck === 1'b1 && irqReq === 1'b1) begin
            v = (expVec.size() > 0) ? expVec.pop_front() : '1;
            check({15'h0, irqHigh, irqVector}, {15'h0, v});
        end
        if (ack === 1'b1 && we === 1'b0) begin
            e = (expRd.size() > 0) ? expRd.pop_front() : '1;
            check(rdat & e[63:32], e[31:0]);
        end
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        logic [31:0] m;
        void'($urandom(32'h424C04D2));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        // reset state; an unmapped offset ignores writes and reads 0
        rd(`TLIC_OFS_IE, 32'h0, 32'hFF);
        check({16'h0, irqVector}, 32'h0);
        // a write without lane 0 leaves the byte-wide enables alone
        bus(1'b1, `TLIC_OFS_IE, 32'hFF, 4'hE);
        rd(`TLIC_OFS_IE, 32'h0, 32'hFF);
        rd(`TLIC_OFS_IP, 32'h80, 32'hFF);
        rd(`TLIC_OFS_EXT_IRQ_PRIORITY_REG1, 32'h0, 32'hFF);
        rd(`TLIC_OFS_EXT_IRQ_PRIORITY_REG2, 32'h0, 32'hF);
        wr(8'h3C, 32'hFFFFFFFF);
        rd(8'h3C, 32'h0, 32'hFFFFFFFF);
        // event while globally off is held, flagged, then served
        wr(`TLIC_OFS_IE, 32'h02);
        wr(`TLIC_OFS_MASK, 32'h4);
        @(posedge sys_clk) srcEvent <= 19'h2;
        @(posedge sys_clk) srcEvent <= 19'h0;
        quiet(8);
        check(32'(intOut), 32'h1);
        rd(`TLIC_OFS_STAT, 32'h4, 32'h4);
        wr(`TLIC_OFS_MASK, 32'h0);
        // the summary output lags the mask write by one edge
        @(posedge sys_clk);
        check(32'(intOut), 32'h0);
        wr(`TLIC_OFS_IE, 32'h82);
        call(1, 1'b0);
        rd(`TLIC_OFS_PSET, 32'h0, 32'h2);
        retire();
        // every vector but source 15's by software set; only sources 0 to 3 self-clear
        wr(`TLIC_OFS_IE, 32'hFF);
        wr(`TLIC_OFS_EXT_IRQ_ENABLE_REG1, 32'hFF);
        wr(`TLIC_OFS_EXT_IRQ_ENABLE_REG2, 32'hE);
        for (int s = 0; s < 19; s++) begin
            if (s == 15) continue;
            m = 32'h1 << s;
            wr(`TLIC_OFS_PSET, m);
            call(s, 1'b0);
            rd(`TLIC_OFS_PSET, (s < 4) ? 32'h0 : m, m);
            wr(`TLIC_OFS_PCLR, m);
            retire();
        end
        // supply warning: live flag, stopped only by its enable
        wr(`TLIC_OFS_EXT_IRQ_ENABLE_REG2, 32'h1);
        @(posedge sys_clk) supplyGood <= 1'b1;
        call(15, 1'b0);
        wr(`TLIC_OFS_PCLR, 32'h8000);
        rd(`TLIC_OFS_PSET, 32'h8000, 32'h8000);
        wr(`TLIC_OFS_EXT_IRQ_ENABLE_REG2, 32'h0);
        retire();
        quiet(6);
        supplyGood <= 1'b0;
        // levels, fixed order, nesting and the one-instruction gap
        wr(`TLIC_OFS_EXT_IRQ_ENABLE_REG2, 32'h8);
        wr(`TLIC_OFS_EXT_IRQ_PRIORITY_REG2, 32'h8);
        wr(`TLIC_OFS_PSET, 32'h40090);
        call(18, 1'b1);
        wr(`TLIC_OFS_PCLR, 32'h40000);
        quiet(8);
        u_cpu.return_from_irq_instr();
        quiet(4);
        u_cpu.instr();
        call(4, 1'b0);
        wr(`TLIC_OFS_PCLR, 32'h10);
        wr(`TLIC_OFS_PSET, 32'h40000);
        call(18, 1'b1);
        wr(`TLIC_OFS_PCLR, 32'h40000);
        retire();
        quiet(6);
        retire();
        call(7, 1'b0);
        retire();
        call(7, 1'b0);
        wr(`TLIC_OFS_PCLR, 32'h80);
        retire();
        check(32'(intOut), 32'h0);
        repeat (4) @(posedge sys_clk);
        check(expVec.size(), 0);
        finish_test();
    end
endmodule // tlic_tb_top
